// ---- core/spi_cfg.svh ----
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define IDX_CTL      6'h00
`define IDX_BRW      6'h06
`define IDX_STAT     6'h08
`define IDX_RXBUF    6'h0C
`define IDX_TXBUF    6'h0E
`define IDX_IE       6'h2A
`define IDX_IFG      6'h2C
`define IDX_IV       6'h2E

// ****************************************
// control word fields
// ****************************************
`define CTL_RST      16'h01C1
`define CTL_WMASK    16'hFFC3
`define CTL_SWMASK   16'h0001
`define CTL_SWRST    0
`define CTL_STEM     1
`define CTL_MODE_LO  9
`define CTL_MODE_HI  10
`define CTL_MST      11
`define CTL_7BIT     12
`define MODE_3PIN    2'h0
`define MODE_STE_HI  2'h1
`define MODE_STE_LO  2'h2

// ****************************************
// status, enable, flag and vector fields
// ****************************************
`define STAT_LISTEN  7
`define STAT_FE      6
`define STAT_OE      5
`define IRQ_TX       1
`define IRQ_RX       0
`define IFG_RST      2'h2
`define IE_RST       2'h0
`define IV_NONE      16'h0000
`define IV_RX        16'h0002
`define IV_TX        16'h0004

// ****************************************
// character lengths
// ****************************************
`define CHAR_LEN8    4'h8
`define CHAR_LEN7    4'h7

`endif

// ---- core/spi_pkg.sv ----
package spi_pkg;

	typedef enum logic {
		PH_IDLE,
		PH_RUN
	} eng_phase_t;

	typedef struct packed {
		logic        master;
		logic        seven;
		logic        loop;
		logic [1:0]  mode;
		logic        stem;
		logic [15:0] prescale;
	} eng_cfg_t;

	typedef struct packed {
		logic       busy;
		logic       done;
		logic       conflict;
		logic [7:0] rx_char;
	} eng_stat_t;

	typedef struct packed {
		eng_phase_t  ph;
		logic        sclk_s1;
		logic        sclk_s2;
		logic        sclk_d;
		logic        din_s1;
		logic        din_s2;
		logic        ste_s1;
		logic        ste_s2;
		logic        sclk_out;
		logic [15:0] div;
		logic [3:0]  cnt;
		logic [7:0]  tx_sh;
		logic [7:0]  rx_sh;
		logic        done;
		logic        conflict;
		logic [7:0]  rx_char;
	} eng_state_t;

	typedef struct packed {
		logic [15:0] ctl;
		logic [15:0] brw;
		logic        loop;
		logic        fe;
		logic        oe;
		logic [7:0]  rxbuf;
		logic [7:0]  txbuf;
		logic        tx_full;
		logic [1:0]  ie;
		logic [1:0]  ifg;
		logic        ack;
		logic [15:0] rdata;
		logic        irq;
	} regs_state_t;

endpackage

// ---- core/spi_shifter.sv ----
`timescale 1ns/1ns
`include "spi_cfg.svh"

module spi_shifter (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             hold,
	input  wire spi_pkg::eng_cfg_t cfg,
	input  wire logic             load,
	input  wire logic [7:0]       tx_char,
	input  wire logic             clk_pin_in,
	input  wire logic             data_pin_in,
	input  wire logic             ste_pin_in,
	output logic                  clk_pin_out,
	output logic                  clk_pin_oe,
	output logic                  data_pin_out,
	output spi_pkg::eng_stat_t    stat
);

	spi_pkg::eng_state_t s_reg;
	spi_pkg::eng_state_t s_next;

	logic        ste_act;
	logic        rx_bit;
	logic        tick;
	logic        lead;
	logic        trail;
	logic        slave_en;
	logic [3:0]  nbits;
	logic [3:0]  cnt_inc;
	logic [15:0] reload;

	// ****************************************
	// shift engine
	// ****************************************
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.conflict = 1'b0;
		// first stage flops feed only the second stage
		s_next.sclk_s1 = clk_pin_in;
		s_next.sclk_s2 = s_reg.sclk_s1;
		s_next.sclk_d = s_reg.sclk_s2;
		s_next.din_s1 = data_pin_in;
		s_next.din_s2 = s_reg.din_s1;
		s_next.ste_s1 = ste_pin_in;
		s_next.ste_s2 = s_reg.ste_s1;
		ste_act = (cfg.mode == `MODE_STE_HI) ? s_reg.ste_s2 :
			(cfg.mode == `MODE_STE_LO) ? !s_reg.ste_s2 : 1'b0;
		slave_en = (cfg.mode == `MODE_3PIN) || ste_act;
		rx_bit = cfg.loop ? s_reg.tx_sh[7] : s_reg.din_s2;
		nbits = cfg.seven ? `CHAR_LEN7 : `CHAR_LEN8;
		cnt_inc = 4'(s_reg.cnt + 4'h1);
		reload = (cfg.prescale == 16'h0000) ? 16'h0000 :
			16'(cfg.prescale - 16'h0001);
		tick = (s_reg.div == 16'h0000);
		lead = cfg.master ? (tick && !s_reg.sclk_out) :
			(s_reg.sclk_s2 && !s_reg.sclk_d);
		trail = cfg.master ? (tick && s_reg.sclk_out) :
			(!s_reg.sclk_s2 && s_reg.sclk_d);
		if (hold) begin
			s_next.ph = spi_pkg::PH_IDLE;
			s_next.sclk_out = 1'b0;
			s_next.cnt = 4'h0;
		end else if (cfg.master && cfg.mode != `MODE_3PIN &&
			!cfg.stem && ste_act) begin
			// another master owns the bus: abort the frame at once, clock output still enabled and held low
			s_next.ph = spi_pkg::PH_IDLE;
			s_next.sclk_out = 1'b0;
			s_next.cnt = 4'h0;
			s_next.conflict = 1'b1;
		end else begin
			unique case (s_reg.ph)
				spi_pkg::PH_IDLE: begin
					if (load) begin
						s_next.ph = spi_pkg::PH_RUN;
						s_next.tx_sh = cfg.seven ?
							{tx_char[6:0], 1'b0} : tx_char;
						s_next.rx_sh = 8'h00;
						s_next.cnt = 4'h0;
						s_next.div = reload;
					end else if (!cfg.master && slave_en && lead) begin
						s_next.ph = spi_pkg::PH_RUN;
						s_next.tx_sh = 8'h00;
						s_next.rx_sh = {7'h00, rx_bit};
						s_next.cnt = 4'h0;
					end
				end
				spi_pkg::PH_RUN: begin
					if (!cfg.master && !slave_en) begin
						s_next.ph = spi_pkg::PH_IDLE;
						s_next.cnt = 4'h0;
					end else begin
						if (cfg.master) begin
							s_next.div = tick ? reload :
								16'(s_reg.div - 16'h0001);
							if (tick) begin
								s_next.sclk_out = !s_reg.sclk_out;
							end
						end
						if (lead) begin
							s_next.rx_sh = {s_reg.rx_sh[6:0], rx_bit};
						end
						if (trail) begin
							s_next.tx_sh = {s_reg.tx_sh[6:0], 1'b0};
							s_next.cnt = cnt_inc;
							if (cnt_inc == nbits) begin
								s_next.ph = spi_pkg::PH_IDLE;
								s_next.done = 1'b1;
								s_next.rx_char = s_reg.rx_sh;
							end
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign clk_pin_out = s_reg.sclk_out;
	assign clk_pin_oe = cfg.master && !hold;
	assign data_pin_out = s_reg.tx_sh[7];
	assign stat.busy = (s_reg.ph == spi_pkg::PH_RUN);
	assign stat.done = s_reg.done;
	assign stat.conflict = s_reg.conflict;
	assign stat.rx_char = s_reg.rx_char;

endmodule

// ---- core/spi_status_buffers_irq.sv ----
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`include "spi_cfg.svh"

// Notes on behaviour
// - loopback feeds transmit output into receiver
// - 4-wire master bus conflict sets framing flag
// - framing flag unused in 3-wire or slave
// - unread receive buffer overwritten sets overrun
// - receive buffer read clears overrun automatically
// - busy bit shows transfer in progress
// - receive buffer low byte, upper byte zero
// - receive read clears error and receive flags
// - 7-bit receive right-aligned, bit 7 zero
// - transmit buffer holds character until loaded
// - transmit buffer write clears transmit flag
// - 7-bit transmit ignores and clears bit 7
// - enables: transmit bit 1, receive bit 0
// - transmit flag set while buffer empty
// - receive flag set on complete character
// - soft reset bit holds logic in reset
// - character length bit: 0 eight, 1 seven
// - vector 0, 2 receive first, 4 transmit

module spi_status_buffers_irq (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        clk_pin_in,
	output logic             clk_pin_out,
	output logic             clk_pin_oe,
	input  wire logic        data_pin_in,
	output logic             data_pin_out,
	input  wire logic        ste_pin_in,
	output logic             irq
);

	spi_pkg::regs_state_t s_reg;
	spi_pkg::regs_state_t s_next;
	spi_pkg::eng_cfg_t    cfg;
	spi_pkg::eng_stat_t   eng;

	logic        swrst;
	logic        seven;
	logic        load;
	logic        wr_ok;
	logic        rd_ok;
	logic        rd_rx;
	logic        wr_tx;
	logic [5:0]  idx;
	logic [15:0] lane;
	logic [1:0]  pend;
	logic [15:0] iv;

	function automatic logic [15:0] merge16(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [15:0] mask
	);
		return (old_v & ~mask) | (new_v & mask);
	endfunction

	// ****************************************
	// configuration seen by the shift engine
	// ****************************************
	assign swrst = s_reg.ctl[`CTL_SWRST];
	assign seven = s_reg.ctl[`CTL_7BIT];
	assign cfg.master = s_reg.ctl[`CTL_MST];
	assign cfg.seven = seven;
	assign cfg.loop = s_reg.loop;
	assign cfg.mode = s_reg.ctl[`CTL_MODE_HI:`CTL_MODE_LO];
	assign cfg.stem = s_reg.ctl[`CTL_STEM];
	assign cfg.prescale = s_reg.brw;

	// buffer goes to the shifter only when it is idle, never mid-frame
	assign load = !swrst && s_reg.tx_full && !eng.busy && !eng.done;

	spi_shifter u_shifter (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.hold         (swrst),
		.cfg          (cfg),
		.load         (load),
		.tx_char      (s_reg.txbuf),
		.clk_pin_in   (clk_pin_in),
		.data_pin_in  (data_pin_in),
		.ste_pin_in   (ste_pin_in),
		.clk_pin_out  (clk_pin_out),
		.clk_pin_oe   (clk_pin_oe),
		.data_pin_out (data_pin_out),
		.stat         (eng)
	);

	// ****************************************
	// bus decode
	// ****************************************
	assign idx = address[7:2];
	assign wr_ok = write && s_reg.ack;
	assign rd_ok = read && s_reg.ack;
	assign rd_rx = rd_ok && idx == `IDX_RXBUF;
	assign wr_tx = wr_ok && idx == `IDX_TXBUF && byteenable[0];
	assign lane = {{8{byteenable[1]}}, {8{byteenable[0]}}};
	assign pend = s_reg.ie & s_reg.ifg;
	assign iv = pend[`IRQ_RX] ? `IV_RX :
		pend[`IRQ_TX] ? `IV_TX : `IV_NONE;
	assign waitrequest = (read || write) && !s_reg.ack;
	assign readdata = {16'h0000, s_reg.rdata};
	assign irq = s_reg.irq;

	// ****************************************
	// register file
	// ****************************************
	always_comb begin
		s_next = s_reg;
		s_next.ack = (read || write) && !s_reg.ack;
		if ((read || write) && !s_reg.ack) begin
			s_next.rdata = 16'h0000;
			if (read) begin
				unique case (idx)
					`IDX_CTL:   s_next.rdata = s_reg.ctl;
					`IDX_BRW:   s_next.rdata = s_reg.brw;
					`IDX_STAT:  s_next.rdata = {8'h00, s_reg.loop,
						s_reg.fe, s_reg.oe, 4'h0, eng.busy};
					`IDX_RXBUF: s_next.rdata = {8'h00, s_reg.rxbuf};
					`IDX_TXBUF: s_next.rdata = {8'h00, s_reg.txbuf};
					`IDX_IE:    s_next.rdata = {14'h0000, s_reg.ie};
					`IDX_IFG:   s_next.rdata = {14'h0000, s_reg.ifg};
					`IDX_IV:    s_next.rdata = iv;
					default:    s_next.rdata = 16'h0000;
				endcase
			end
		end
		if (load) begin
			s_next.tx_full = 1'b0;
		end
		if (wr_ok) begin
			unique case (idx)
				`IDX_CTL: begin
					// fields freeze outside reset; reset bit stays writable
					s_next.ctl = merge16(s_reg.ctl, writedata[15:0],
						lane & (swrst ? `CTL_WMASK : `CTL_SWMASK));
				end
				`IDX_BRW: begin
					if (swrst) begin
						s_next.brw = merge16(s_reg.brw, writedata[15:0], lane);
					end
				end
				`IDX_STAT: begin
					// writable at any time through the low byte only; software keeps to reset time
					if (byteenable[0]) begin
						s_next.loop = writedata[`STAT_LISTEN];
						s_next.fe = writedata[`STAT_FE];
						s_next.oe = writedata[`STAT_OE];
					end
				end
				`IDX_TXBUF: begin
					if (byteenable[0]) begin
						s_next.txbuf = seven ? {1'b0, writedata[6:0]} :
							writedata[7:0];
						s_next.tx_full = 1'b1;
						s_next.ifg[`IRQ_TX] = 1'b0;
					end
				end
				`IDX_IE: begin
					if (byteenable[0]) begin
						s_next.ie = writedata[1:0];
					end
				end
				`IDX_IFG: begin
					if (byteenable[0]) begin
						s_next.ifg = writedata[1:0];
					end
				end
				default: begin
				end
			endcase
		end
		if (rd_rx) begin
			s_next.ifg[`IRQ_RX] = 1'b0;
			s_next.oe = 1'b0;
			s_next.fe = 1'b0;
		end
		// hardware sets below override software clears above
		if (!s_next.tx_full) begin
			s_next.ifg[`IRQ_TX] = 1'b1;
		end
		if (eng.done) begin
			s_next.rxbuf = seven ? {1'b0, eng.rx_char[6:0]} :
				eng.rx_char;
			s_next.ifg[`IRQ_RX] = 1'b1;
			if (s_reg.ifg[`IRQ_RX] && !rd_rx) begin
				s_next.oe = 1'b1;
			end
		end
		if (eng.conflict && cfg.master && cfg.mode != `MODE_3PIN) begin
			s_next.fe = 1'b1;
		end
		if (swrst) begin
			s_next.fe = 1'b0;
			s_next.oe = 1'b0;
			s_next.tx_full = 1'b0;
			s_next.ifg = `IFG_RST;
		end
		s_next.irq = |(s_next.ie & s_next.ifg);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.ctl <= `CTL_RST;
			s_reg.ifg <= `IFG_RST;
			s_reg.ie <= `IE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	overrun_set_a: assert property (
		eng.done && s_reg.ifg[`IRQ_RX] && !rd_rx && !swrst |=> s_reg.oe)
		else $error("overrun not flagged");
	rx_read_clear_a: assert property (
		rd_rx && !eng.done && !swrst |=> !s_reg.ifg[`IRQ_RX] && !s_reg.oe)
		else $error("receive read left flags set");
	rx_hi_zero_a: assert property (
		read && !s_reg.ack && idx == `IDX_RXBUF |=> readdata[15:8] == 8'h00)
		else $error("receive upper byte not zero");
	rx_seven_a: assert property (
		eng.done && seven |=> s_reg.rxbuf[7] == 1'b0 && s_reg.ifg[`IRQ_RX])
		else $error("7-bit receive bit 7 set");
	tx_seven_a: assert property (
		wr_tx && seven |=> s_reg.txbuf[7] == 1'b0)
		else $error("7-bit transmit bit 7 kept");
	tx_write_clr_a: assert property (
		wr_tx && !swrst |=> !s_reg.ifg[`IRQ_TX] && s_reg.tx_full)
		else $error("transmit write did not clear flag");
	tx_empty_set_a: assert property (
		!s_reg.tx_full && !wr_tx |=> s_reg.ifg[`IRQ_TX])
		else $error("transmit flag not set while empty");
	fe_unused_a: assert property (
		(!cfg.master || cfg.mode == `MODE_3PIN) && !s_reg.fe &&
		!(wr_ok && idx == `IDX_STAT) |=> !s_reg.fe)
		else $error("framing flag set outside 4-wire master");
	soft_hold_a: assert property (
		swrst [*2] |-> !eng.busy && s_reg.ifg == `IFG_RST && !s_reg.oe)
		else $error("soft reset does not hold the unit");
	irq_req_a: assert property (
		irq == |(s_reg.ie & s_reg.ifg))
		else $error("interrupt request mismatch");
	vector_prio_a: assert property (
		pend[`IRQ_RX] |-> iv == `IV_RX)
		else $error("receive vector not first");
	vector_low_a: assert property (
		!pend[`IRQ_RX] |-> iv == (pend[`IRQ_TX] ? `IV_TX : `IV_NONE))
		else $error("vector wrong without receive");
	busy_read_a: assert property (
		read && !s_reg.ack && idx == `IDX_STAT |=> readdata[0] == $past(eng.busy))
		else $error("busy bit does not follow engine");
	rx_flag_a: assert property (
		eng.done && !swrst |=> s_reg.ifg[`IRQ_RX])
		else $error("receive flag not set");
	rx_store_a: assert property (
		eng.done && !seven |=> s_reg.rxbuf == $past(eng.rx_char))
		else $error("received character not stored");
	tx_hold_a: assert property (
		s_reg.tx_full && !load && !swrst && !wr_tx |=>
		s_reg.tx_full && $stable(s_reg.txbuf))
		else $error("transmit character not held");
	ie_write_a: assert property (
		wr_ok && idx == `IDX_IE && byteenable[0] |=>
		s_reg.ie == $past(writedata[1:0]))
		else $error("enable write lost");
	fe_conflict_a: assert property (
		eng.conflict && cfg.master && cfg.mode != `MODE_3PIN && !swrst
		|=> s_reg.fe)
		else $error("bus conflict not flagged");
	overrun_only_a: assert property (
		!s_reg.oe && !(eng.done && s_reg.ifg[`IRQ_RX]) &&
		!(wr_ok && idx == `IDX_STAT) |=> !s_reg.oe)
		else $error("overrun set without cause");
	soft_oe_a: assert property (
		swrst |-> !clk_pin_oe)
		else $error("clock driven in soft reset");

	rx_done_c: cover property (eng.done ##1 s_reg.ifg[`IRQ_RX]);
	overrun_c: cover property ($rose(s_reg.oe));
	tx_load_c: cover property (load ##1 eng.busy);
	conflict_c: cover property ($rose(s_reg.fe) && !swrst);
	slave_rx_c: cover property (eng.done && !cfg.master);

endmodule

// ---- dv/spi_far_end.sv ----
`timescale 1ns/1ns
// ****
// far-end device on the serial pins
// ****
module spi_far_end (
	input  wire logic clk_pin_out,
	input  wire logic data_pin_out,
	output logic      clk_pin_in,
	output wire logic data_pin_in,
	output logic      ste_pin_in
);
	logic [7:0] out_sh;
	logic [7:0] rx_q;
	int         bits;
	// spent bits refill with the inverse of bit 0: a late sample never matches by luck
	assign data_pin_in = out_sh[7];
	initial begin
		clk_pin_in = 1'b0;
		ste_pin_in = 1'b1;
		out_sh = 8'h00;
		rx_q = 8'h00;
		bits = 0;
	end
	// as slave: msb first, sample on rise, shift on fall
	always @(posedge clk_pin_out) rx_q = {rx_q[6:0], data_pin_out};
	always @(negedge clk_pin_out) begin
		out_sh = {out_sh[6:0], ~out_sh[0]};
		bits++;
	end
	task automatic load(input logic [7:0] b);
		out_sh = b;
	endtask
	// as master: clock stands low outside the frame, 64 ns period
	task automatic send_frame(input logic [7:0] b);
		out_sh = b;
		#13;
		repeat (8) begin
			#32 clk_pin_in = 1'b1;
			#32 clk_pin_in = 1'b0;
			out_sh = {out_sh[6:0], ~out_sh[0]};
		end
	endtask
endmodule

// ---- dv/tb_spi_status_buffers_irq.sv ----
`timescale 1ns/1ns
module tb_spi_status_buffers_irq;
	logic        mclk;
	logic        rst_n;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        clk_pin_in;
	logic        clk_pin_out;
	logic        clk_pin_oe;
	logic        data_pin_in;
	logic        data_pin_out;
	logic        ste_pin_in;
	logic        irq;
	int          error_cnt;
	int          check_count;
	logic [31:0] seed;
	logic [31:0] r;
	logic [15:0] q;
	int          nb;
	logic [7:0]  adr_tab [9] = '{8'h00, 8'h18, 8'h20, 8'h30, 8'h38,
		8'hA8, 8'hB0, 8'hB8, 8'h04};
	logic [15:0] rst_tab [9] = '{16'h01C1, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0000};

	spi_status_buffers_irq dut (.mclk(mclk), .rst_n(rst_n),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out),
		.clk_pin_oe(clk_pin_oe), .data_pin_in(data_pin_in),
		.data_pin_out(data_pin_out), .ste_pin_in(ste_pin_in), .irq(irq));
	spi_far_end far (.clk_pin_out(clk_pin_out), .data_pin_out(data_pin_out),
		.clk_pin_in(clk_pin_in), .data_pin_in(data_pin_in),
		.ste_pin_in(ste_pin_in));

	initial mclk = 1'b0;
	always #4 mclk = ~mclk;

	// ****
	// helpers
	// ****
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// what the far end shifts out after a full character
	function automatic logic [7:0] fill(input logic [7:0] v);
		repeat (8) v = {v[6:0], ~v[0]};
		return v;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] rd);
		int n;
		n = 0;
		@(posedge mclk);
		address <= a;
		write <= wr;
		read <= ~wr;
		writedata <= {16'h0000, d};
		// answer and read data are taken at the rising edge only
		do begin
			@(posedge mclk);
			n++;
			if (n > 20) begin
				error_cnt++;
				$display("Error %0t: bus timeout", $time);
				finish_test();
			end
		end while (waitrequest !== 1'b0);
		rd = readdata[15:0];
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000, q);
		chk(q, e);
	endtask
	// polls are bounded: a hang counts as a mismatch
	task automatic wait_reg(input logic [7:0] a, input logic [15:0] m,
		input logic [15:0] v);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 16'h0000, q);
			n++;
			if (n > 300) begin
				error_cnt++;
				$display("Error %0t: poll timeout", $time);
				finish_test();
			end
		end while ((q & m) !== v);
	endtask
	task automatic wait_done(input int nb);
		for (int n = 0; n < 2000 && far.bits < nb; n++) @(posedge mclk);
		if (far.bits < nb) begin
			error_cnt++;
			$display("Error %0t: frame timeout", $time);
			finish_test();
		end
		wait_reg(8'h20, 16'h0001, 16'h0000);
	endtask
	task automatic xfer(input logic [7:0] t, input logic [7:0] s,
		input int len);
		far.load(s);
		nb = far.bits + len;
		put(8'h38, {8'h00, t});
		bus(1'b0, 8'h20, 16'h0000, q);
		chk({15'h0000, q[0]}, 16'h0001);
		wait_done(nb);
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		seed = 32'hada0_e959;
		error_cnt = 0;
		check_count = 0;
		rst_n = 1'b0;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0000_0000;
		byteenable = 4'h3;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rd_chk(adr_tab[i], rst_tab[i]);
		end
		chk({15'h0000, clk_pin_oe}, 16'h0000);
		put(8'h18, 16'h0004);
		put(8'h00, 16'h0801);
		put(8'h00, 16'h0800);
		rd_chk(8'h00, 16'h0800);
		chk({15'h0000, clk_pin_oe}, 16'h0001);
		put(8'hA8, 16'h0001);
		@(negedge mclk);
		chk({15'h0000, irq}, 16'h0000);
		rd_chk(8'hB8, 16'h0000);
		put(8'hA8, 16'h0003);
		@(negedge mclk);
		chk({15'h0000, irq}, 16'h0001);
		rd_chk(8'hB8, 16'h0004);
		// three-wire master: an active select pin must not flag
		far.ste_pin_in <= 1'b0;
		repeat (3) begin
			r = rnd();
			xfer(r[7:0], r[15:8], 8);
			chk({8'h00, far.rx_q}, {8'h00, r[7:0]});
			rd_chk(8'hB8, 16'h0002);
			rd_chk(8'h30, {8'h00, r[15:8]});
			rd_chk(8'hB0, 16'h0002);
			rd_chk(8'h20, 16'h0000);
		end
		// second character waits in the buffer, first is never read
		r = rnd();
		far.load(r[15:8]);
		nb = far.bits + 16;
		put(8'h38, {8'h00, r[7:0]});
		put(8'h38, {8'h00, r[23:16]});
		rd_chk(8'hB0, 16'h0000);
		wait_done(nb);
		chk({8'h00, far.rx_q}, {8'h00, r[23:16]});
		rd_chk(8'h20, 16'h0020);
		rd_chk(8'h30, {8'h00, fill(r[15:8])});
		rd_chk(8'h20, 16'h0000);
		// seven-bit characters
		put(8'h00, 16'h0801);
		@(negedge mclk);
		chk({15'h0000, clk_pin_oe}, 16'h0000);
		rd_chk(8'hB0, 16'h0002);
		put(8'h00, 16'h1801);
		put(8'h00, 16'h1800);
		r = rnd();
		xfer(r[7:0] | 8'h80, {r[14:8], 1'b0}, 7);
		chk({9'h000, far.rx_q[6:0]}, {9'h000, r[6:0]});
		rd_chk(8'h30, {9'h000, r[14:8]});
		// loopback: far end sends the inverse
		put(8'h00, 16'h1801);
		put(8'h00, 16'h0801);
		put(8'h20, 16'h0080);
		put(8'h00, 16'h0800);
		rd_chk(8'h20, 16'h0080);
		r = rnd();
		xfer(r[7:0], ~r[7:0], 8);
		rd_chk(8'h30, {8'h00, r[7:0]});
		// four-wire master, select active low and held active by others
		put(8'h00, 16'h0801);
		put(8'h20, 16'h0000);
		put(8'h00, 16'h0C01);
		put(8'h00, 16'h0C00);
		put(8'h38, 16'h00A5);
		wait_reg(8'h20, 16'h0040, 16'h0040);
		far.ste_pin_in <= 1'b1;
		repeat (8) @(posedge mclk);
		bus(1'b0, 8'h30, 16'h0000, q);
		bus(1'b0, 8'h20, 16'h0000, q);
		chk({15'h0000, q[6]}, 16'h0000);
		// slave receive, select active high, on the 64 ns link clock
		put(8'h00, 16'h0801);
		put(8'h00, 16'h0201);
		put(8'h00, 16'h0200);
		r = rnd();
		far.send_frame(r[7:0]);
		wait_reg(8'hB0, 16'h0001, 16'h0001);
		rd_chk(8'h30, {8'h00, r[7:0]});
		// deselected slave must ignore a whole frame
		far.ste_pin_in <= 1'b0;
		repeat (4) @(posedge mclk);
		far.send_frame(r[15:8]);
		repeat (8) @(posedge mclk);
		rd_chk(8'hB0, 16'h0002);
		rd_chk(8'h20, 16'h0000);
		finish_test();
	end
endmodule
